// ### flash_bank_dev.sv
/*
  flash bank switch device: control register, user/boot mapping, security
  lock of the function code, and the flash routines with their own timer.
  assumes the flash array answers a read one cycle after its request and
  that strap pins and the security byte are steady around reset.
*/
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module flash_bank_dev
  import flash_bank_pkg::*;
#(
  parameter int WRITE_T = WRITE_TICKS,
  parameter int ERASE_T = ERASE_TICKS
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // cpu link
  flash_bank_if.dev LINK,
  // strap pins
  input wire logic PROGRAM_STORE_STROBE_N,
  input wire logic EXTERNAL_ACCESS_N,
  input wire logic ALE,
  // security byte as stored at the top of flash
  input wire logic [7:0] SEC_BYTE,
  // flash array
  output logic FL_REQ,
  output fop_e FL_OP,
  output logic [15:0] FL_ADDR,
  output logic [7:0] FL_WDATA,
  input wire logic [7:0] FL_RDATA,
  output logic FL_FETCH_EN,
  // status
  output logic HIGH_VOLTAGE
);
  typedef enum logic [2:0] {ST_IDLE, ST_RDWAIT, ST_RDCAP, ST_HV, ST_VERIFY, ST_DONE} dev_e;

  // ----------------------------------------
  // pin synchronisers and reset straps
  // ----------------------------------------
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic rel_q;
  logic ea_q;
  logic sec_q;

  always_ff @(posedge CLK) begin
    pin_s1_q <= {PROGRAM_STORE_STROBE_N, EXTERNAL_ACCESS_N, ALE};
    pin_s2_q <= pin_s1_q;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rel_q <= 1'b1;
    end else begin
      rel_q <= 1'b0;
    end
  end

  dev_e state_q;
  fop_e op_q;
  logic tick;
  logic [12:0] tick_cnt_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ea_q <= 1'b0;
      sec_q <= 1'b0;
    end else if (rel_q) begin
      ea_q <= pin_s2_q[1];
      sec_q <= (SEC_BYTE != SEC_OFF0) && (SEC_BYTE != SEC_OFF1);
    end else if (state_q == ST_HV && tick && tick_cnt_q == 13'h0001 && op_q == FOP_FULL) begin
      sec_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // program space mapping
  // ----------------------------------------
  logic sel_hi_q;
  logic sel_lo_q;
  logic done_q;
  logic [3:0] code_q;
  logic in_win;
  logic boot_hit;
  logic was_boot_q;
  logic src_int_q;
  logic busy;

  assign in_win = (LINK.pc_addr[15:10] == BOOT_WIN);
  assign boot_hit = (sel_hi_q & sel_lo_q) | ((sel_hi_q | sel_lo_q) & in_win);
  assign busy = (state_q != ST_IDLE);
  assign LINK.map_boot = boot_hit;
  assign LINK.map_ext = !boot_hit && (!ea_q || LINK.pc_addr >= FLASH_END);
  assign LINK.fetch_stall = busy && !boot_hit;

  always_ff @(posedge CLK) begin
    if (RST) begin
      FL_FETCH_EN <= 1'b0;
    end else begin
      FL_FETCH_EN <= LINK.pc_valid && !boot_hit && !LINK.map_ext && !busy;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      was_boot_q <= 1'b0;
      src_int_q <= 1'b1;
    end else if (rel_q) begin
      src_int_q <= pin_s2_q[1];
    end else if (LINK.pc_valid) begin
      was_boot_q <= boot_hit;
      src_int_q <= !boot_hit && !LINK.map_ext;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic fmc_wr;
  logic code_ok;

  assign fmc_wr = LINK.sfr_wr && (LINK.sfr_addr == FMC_ADDR);
  assign code_ok = !sec_q || src_int_q || (LINK.sfr_wdata[3:0] == FC_FULL);

  always_ff @(posedge CLK) begin
    if (RST) begin
      sel_hi_q <= FMC_RESET[SEL_HI_BIT];
      sel_lo_q <= FMC_RESET[SEL_LO_BIT];
    end else if (rel_q) begin
      sel_hi_q <= !pin_s2_q[2] && !pin_s2_q[1] && pin_s2_q[0];
      sel_lo_q <= !pin_s2_q[2] && !pin_s2_q[1] && pin_s2_q[0];
    end else if (state_q == ST_DONE) begin
      sel_hi_q <= 1'b0;
      sel_lo_q <= 1'b0;
    end else if (LINK.pc_valid && LINK.pc_ret && was_boot_q && !in_win) begin
      sel_hi_q <= 1'b0;
      sel_lo_q <= 1'b0;
    end else if (LINK.pc_valid && sel_hi_q && !sel_lo_q && !in_win) begin
      sel_hi_q <= 1'b0;
    end else if (fmc_wr) begin
      sel_hi_q <= LINK.sfr_wdata[SEL_HI_BIT];
      sel_lo_q <= LINK.sfr_wdata[SEL_LO_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      done_q <= FMC_RESET[DONE_BIT];
    end else if (state_q == ST_DONE) begin
      done_q <= 1'b1;
    end else if (fmc_wr) begin
      done_q <= LINK.sfr_wdata[DONE_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      code_q <= FC_RESET;
    end else if (fmc_wr && code_ok) begin
      code_q <= LINK.sfr_wdata[3:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      LINK.sfr_rdata <= FMC_RESET;
    end else begin
      LINK.sfr_rdata <= {sel_hi_q, sel_lo_q, HIGH_VOLTAGE, done_q, code_q};
    end
  end

  // ----------------------------------------
  // flash timer
  // ----------------------------------------
  logic [7:0] div_q;

  assign tick = (div_q == 8'(TICK_DIV - 1));

  always_ff @(posedge CLK) begin
    if (RST || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ----------------------------------------
  // routine sequencer
  // ----------------------------------------
  logic [7:0] acc_q;
  logic [15:0] data_pointer_q;
  logic call_ok;
  fop_e call_op;

  always_comb begin
    call_op = FOP_READ;
    call_ok = boot_hit;
    unique case (LINK.pc_addr)
      EP_READ: call_ok = call_ok && (code_q == FC_BYTE);
      EP_WRITE: begin
        call_op = FOP_WRITE;
        call_ok = call_ok && (code_q == FC_BYTE);
      end
      EP_PAGE: begin
        call_op = FOP_PAGE;
        call_ok = call_ok && (code_q == FC_PAGE);
      end
      EP_BLOCK: begin
        call_op = FOP_BLOCK;
        call_ok = call_ok && (code_q == FC_BLOCK);
      end
      EP_FULL: begin
        call_op = FOP_FULL;
        call_ok = call_ok && (code_q == FC_FULL);
      end
      default: call_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      op_q <= FOP_READ;
      acc_q <= 8'h00;
      data_pointer_q <= 16'h0000;
      tick_cnt_q <= 13'h0000;
      FL_REQ <= 1'b0;
      FL_OP <= FOP_READ;
      FL_ADDR <= 16'h0000;
      FL_WDATA <= 8'h00;
    end else begin
      FL_REQ <= 1'b0;
      unique case (state_q)
        ST_IDLE: if (LINK.call_req) begin
          op_q <= call_op;
          acc_q <= LINK.call_acc;
          data_pointer_q <= LINK.call_data_pointer;
          FL_ADDR <= LINK.call_data_pointer;
          FL_WDATA <= LINK.call_acc;
          FL_OP <= call_op;
          FL_REQ <= call_ok;
          tick_cnt_q <= 13'(call_op == FOP_WRITE ? WRITE_T : ERASE_T);
          if (!call_ok) begin
            state_q <= ST_DONE;
          end else if (call_op == FOP_READ) begin
            state_q <= ST_RDWAIT;
          end else begin
            state_q <= ST_HV;
          end
        end
        ST_RDWAIT: state_q <= ST_RDCAP;
        ST_RDCAP: begin
          acc_q <= FL_RDATA;
          state_q <= ST_DONE;
        end
        ST_HV: if (tick) begin
          tick_cnt_q <= tick_cnt_q - 13'h0001;
          if (tick_cnt_q == 13'h0001) begin
            state_q <= (op_q == FOP_WRITE) ? ST_VERIFY : ST_DONE;
            unique case (op_q)
              FOP_PAGE: begin
                acc_q <= ACC_PAGE;
                data_pointer_q <= data_pointer_q & PAGE_ALIGN;
              end
              FOP_BLOCK: begin
                acc_q <= ACC_BLOCK;
                data_pointer_q <= {data_pointer_q[15:8], DPL_BLOCK};
              end
              FOP_FULL: begin
                acc_q <= ACC_FULL;
                data_pointer_q <= DATA_POINTER_FULL;
              end
              default: acc_q <= acc_q;
            endcase
          end
        end
        ST_VERIFY: begin
          FL_OP <= FOP_READ;
          FL_REQ <= 1'b1;
          state_q <= ST_RDWAIT;
        end
        ST_DONE: state_q <= ST_IDLE;
      endcase
    end
  end

  assign HIGH_VOLTAGE = (state_q == ST_HV);
  assign LINK.call_ack = (state_q == ST_DONE);
  assign LINK.ret_acc = acc_q;
  assign LINK.ret_data_pointer = data_pointer_q;
endmodule // flash_bank_dev

// ### flash_bank_pkg.sv
/*
  constants shared by the flash bank switch device, its cpu-side controller,
  the assertions on the link between them and the bench.
  assumes one 200 mhz clock and a synchronous active-high reset.
*/
package flash_bank_pkg;
  // ----------------------------------------
  // control register
  // ----------------------------------------
  localparam logic [7:0] FMC_ADDR = 8'hfb;
  localparam int SEL_HI_BIT = 7;
  localparam int SEL_LO_BIT = 6;
  localparam int HV_BIT = 5;
  localparam int DONE_BIT = 4;
  localparam logic [7:0] FMC_RESET = 8'h00;
  localparam logic [7:0] FMC_SEL_LO = 8'h40;
  localparam logic [3:0] FC_RESET = 4'h0;
  localparam logic [3:0] FC_BYTE = 4'h5;
  localparam logic [3:0] FC_PAGE = 4'hc;
  localparam logic [3:0] FC_BLOCK = 4'h3;
  localparam logic [3:0] FC_FULL = 4'ha;
  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [5:0] BOOT_WIN = 6'h3f;
  localparam logic [15:0] FLASH_END = 16'hc000;
  localparam logic [15:0] RET_PC = 16'h0100;
  localparam logic [15:0] EP_READ = 16'hffba;
  localparam logic [15:0] EP_WRITE = 16'hffad;
  localparam logic [15:0] EP_PAGE = 16'hffaa;
  localparam logic [15:0] EP_BLOCK = 16'hffa5;
  localparam logic [15:0] EP_FULL = 16'hffa0;
  // ----------------------------------------
  // routine results and security codes
  // ----------------------------------------
  localparam logic [7:0] ACC_PAGE = 8'h08;
  localparam logic [7:0] ACC_BLOCK = 8'h02;
  localparam logic [7:0] ACC_FULL = 8'h0a;
  localparam logic [7:0] DPL_BLOCK = 8'h08;
  localparam logic [15:0] DATA_POINTER_FULL = 16'h0018;
  localparam logic [15:0] PAGE_ALIGN = 16'hffe0;
  localparam logic [7:0] SEC_OFF0 = 8'h00;
  localparam logic [7:0] SEC_OFF1 = 8'hff;
  // ----------------------------------------
  // flash timer
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TICK_NS = 1000;
  localparam int TICK_DIV = TICK_NS * CLK_MHZ / 1000;
  localparam int WRITE_TIME_US = 2500;
  localparam int ERASE_TIME_US = 5000;
  localparam int WRITE_TICKS = WRITE_TIME_US * 1000 / TICK_NS;
  localparam int ERASE_TICKS = ERASE_TIME_US * 1000 / TICK_NS;
  // ----------------------------------------
  // controller registers
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DATA_POINTER_OFF = 8'h04;
  localparam logic [7:0] ACC_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0c;
  localparam logic [7:0] RES_OFF = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {FOP_READ, FOP_WRITE, FOP_PAGE, FOP_BLOCK, FOP_FULL} fop_e;
endpackage

// ### flash_bank_if.sv
/*
  link between the cpu core side and the flash bank switch device.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface flash_bank_if;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic pc_valid;
  logic pc_ret;
  logic [15:0] pc_addr;
  logic map_boot;
  logic map_ext;
  logic fetch_stall;
  logic call_req;
  logic [7:0] call_acc;
  logic [15:0] call_data_pointer;
  logic call_ack;
  logic [7:0] ret_acc;
  logic [15:0] ret_data_pointer;

  modport dev (input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, pc_valid, pc_ret, pc_addr,
               call_req, call_acc, call_data_pointer,
               output sfr_rdata, map_boot, map_ext, fetch_stall, call_ack, ret_acc,
               ret_data_pointer);
  modport cpu (output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, pc_valid, pc_ret, pc_addr,
               call_req, call_acc, call_data_pointer,
               input sfr_rdata, map_boot, map_ext, fetch_stall, call_ack, ret_acc,
               ret_data_pointer);
endinterface

// ### flash_bank_cpu.sv
/*
  cpu-side controller: takes routine orders over axi4-lite and runs the
  calling sequence on the link to the flash bank switch device.
  assumes the device on the link shares the clock.
*/
`timescale 1ns/1ps
module flash_bank_cpu
  import flash_bank_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // axi4-lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // link to device
  flash_bank_if.cpu LINK,
  // interrupt gate
  output logic IRQ_DISABLE
);
  typedef enum logic [2:0] {H_IDLE, H_SETFM, H_CALL, H_RET, H_CLEAR, H_RDFM, H_RDCAP} host_e;

  host_e state_q;
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [2:0] op_q;
  logic go;
  logic done_q;
  logic [15:0] data_pointer_q;
  logic [7:0] acc_q;
  logic [15:0] rdptr_q;
  logic [7:0] racc_q;
  logic [7:0] fmc_q;
  logic wr_fire;
  logic wr_map;

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  assign AWREADY = !aw_q && !BVALID;
  assign WREADY = !w_q && !BVALID;
  assign wr_fire = aw_q && w_q && !BVALID;
  assign wr_map = awaddr_q inside {CTRL_OFF, DATA_POINTER_OFF, ACC_OFF, STAT_OFF};
  assign go = wr_fire && awaddr_q == CTRL_OFF && wstrb_q[0] && wdata_q[0];

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_q <= 1'b1;
        awaddr_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      op_q <= 3'h0;
      data_pointer_q <= 16'h0000;
      acc_q <= 8'h00;
    end else if (wr_fire && state_q == H_IDLE) begin
      if (awaddr_q == CTRL_OFF && wstrb_q[0]) begin
        op_q <= wdata_q[3:1];
      end
      if (awaddr_q == DATA_POINTER_OFF && wstrb_q[0]) begin
        data_pointer_q[7:0] <= wdata_q[7:0];
      end
      if (awaddr_q == DATA_POINTER_OFF && wstrb_q[1]) begin
        data_pointer_q[15:8] <= wdata_q[15:8];
      end
      if (awaddr_q == ACC_OFF && wstrb_q[0]) begin
        acc_q <= wdata_q[7:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      done_q <= 1'b0;
    end else if (state_q == H_RDCAP) begin
      done_q <= 1'b1;
    end else if (wr_fire && awaddr_q == STAT_OFF && wstrb_q[0] && wdata_q[1]) begin
      done_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  assign ARREADY = !RVALID;

  always_ff @(posedge CLK) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP <= RESP_OKAY;
      unique case (ARADDR)
        CTRL_OFF: RDATA <= {28'h0000000, op_q, 1'b0};
        DATA_POINTER_OFF: RDATA <= {16'h0000, data_pointer_q};
        ACC_OFF: RDATA <= {24'h000000, acc_q};
        STAT_OFF: RDATA <= {16'h0000, fmc_q, 6'h00, done_q, state_q != H_IDLE};
        RES_OFF: RDATA <= {8'h00, racc_q, rdptr_q};
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= RESP_SLVERR;
        end
      endcase
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // calling sequence
  // ----------------------------------------
  logic [3:0] code;
  logic [15:0] entry;
  logic [2:0] op_sel;

  // the go write stores op_q on the same edge, so decode the fresh value then
  assign op_sel = go ? wdata_q[3:1] : op_q;

  always_comb begin
    code = FC_BYTE;
    entry = EP_READ;
    unique case (op_sel)
      3'h1: entry = EP_WRITE;
      3'h2: begin
        code = FC_PAGE;
        entry = EP_PAGE;
      end
      3'h3: begin
        code = FC_BLOCK;
        entry = EP_BLOCK;
      end
      3'h4: begin
        code = FC_FULL;
        entry = EP_FULL;
      end
      default: entry = EP_READ;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= H_IDLE;
      LINK.sfr_wr <= 1'b0;
      LINK.sfr_rd <= 1'b0;
      LINK.sfr_addr <= FMC_ADDR;
      LINK.sfr_wdata <= 8'h00;
      LINK.pc_valid <= 1'b0;
      LINK.pc_ret <= 1'b0;
      LINK.pc_addr <= RESET_PC;
      LINK.call_req <= 1'b0;
      LINK.call_acc <= 8'h00;
      LINK.call_data_pointer <= 16'h0000;
      racc_q <= 8'h00;
      rdptr_q <= 16'h0000;
      fmc_q <= 8'h00;
    end else begin
      LINK.sfr_wr <= 1'b0;
      LINK.sfr_rd <= 1'b0;
      LINK.pc_valid <= 1'b0;
      LINK.pc_ret <= 1'b0;
      unique case (state_q)
        H_IDLE: if (go) begin
          LINK.call_acc <= acc_q;
          LINK.call_data_pointer <= data_pointer_q;
          LINK.sfr_wr <= 1'b1;
          LINK.sfr_wdata <= FMC_SEL_LO | {4'h0, code};
          state_q <= H_SETFM;
        end
        H_SETFM: begin
          LINK.pc_valid <= 1'b1;
          LINK.pc_addr <= entry;
          LINK.call_req <= 1'b1;
          state_q <= H_CALL;
        end
        H_CALL: if (LINK.call_ack) begin
          LINK.call_req <= 1'b0;
          racc_q <= LINK.ret_acc;
          rdptr_q <= LINK.ret_data_pointer;
          LINK.pc_valid <= 1'b1;
          LINK.pc_ret <= 1'b1;
          LINK.pc_addr <= RET_PC;
          state_q <= H_RET;
        end else begin
          LINK.pc_valid <= 1'b1;
        end
        H_RET: begin
          LINK.sfr_rd <= 1'b1;
          state_q <= H_RDFM;
        end
        H_RDFM: state_q <= H_RDCAP;
        H_RDCAP: begin
          fmc_q <= LINK.sfr_rdata;
          LINK.sfr_wr <= 1'b1;
          LINK.sfr_wdata <= FMC_RESET;
          state_q <= H_CLEAR;
        end
        H_CLEAR: state_q <= H_IDLE;
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign IRQ_DISABLE = (state_q != H_IDLE);
endmodule // flash_bank_cpu

// ### flash_bank_sva.sv
/*
  assertions on the link between the cpu end and the device end.
  assumes the bench hands the interface signals over by name.
*/
`timescale 1ns/1ps
module flash_bank_sva
  import flash_bank_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // link
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic pc_valid,
  input wire logic pc_ret,
  input wire logic [15:0] pc_addr,
  input wire logic map_boot,
  input wire logic call_req,
  input wire logic call_ack,
  input wire logic [7:0] ret_acc,
  input wire logic [15:0] ret_data_pointer
);
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  localparam int ACK_MAX = 900;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  AST_SFR_ADDR: assert property (sfr_wr |-> sfr_addr == FMC_ADDR)
    else $error("control write off address");
  AST_CALL_ORDER: assert property ($rose(call_req) |-> $past(sfr_wr) && $past(sfr_wdata[7:4]) == 4'h4)
    else $error("call without select setup");
  AST_ENTRY: assert property ($rose(call_req) |-> pc_addr[15:10] == BOOT_WIN)
    else $error("entry outside boot window");
  AST_MAP_BOOT: assert property (call_req && !call_ack |-> map_boot)
    else $error("boot not mapped in call");
  AST_RET_MAP: assert property (pc_valid && pc_ret |-> !map_boot)
    else $error("boot mapped after return");
  AST_RET_SFR: assert property (call_ack |-> ##2 (sfr_rdata[7:6] == 2'b00 && sfr_rdata[4]))
    else $error("selects not cleared on return");
  AST_READ_LAT: assert property ($rose(call_req) && pc_addr == EP_READ |-> ##3 call_ack)
    else $error("read answer late");
  AST_ACK_BOUND: assert property ($rose(call_req) |-> ##[1:ACK_MAX] call_ack)
    else $error("routine never returned");
  AST_PAGE_RES: assert property (call_ack && pc_addr == EP_PAGE && sfr_rdata[3:0] == FC_PAGE
    |-> ret_data_pointer[4:0] == 5'h00 && ret_acc == ACC_PAGE)
    else $error("page result wrong");
  AST_FULL_RES: assert property (call_ack && pc_addr == EP_FULL && sfr_rdata[3:0] == FC_FULL
    |-> ret_data_pointer == DATA_POINTER_FULL && ret_acc == ACC_FULL)
    else $error("full erase result wrong");
  cover property (call_ack && pc_addr == EP_FULL);
  cover property (call_ack && pc_addr == EP_WRITE);
  cover property (pc_valid && pc_ret);
endmodule // flash_bank_sva

// ### flash_boot_bank_switch_control_tb.sv
/*
  bench joining the cpu end and the device end, driving axi4-lite.
  assumes shortened timer counts and a small flash array model.
*/
`timescale 1ns/1ps
module flash_boot_bank_switch_control_tb;
  import flash_bank_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strobe_n = 1'b1, ext_n = 1'b1, ale = 1'b1;
  logic [7:0] sec_byte = 8'h00, awaddr = 8'h00, araddr = 8'h00, fl_rdata = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq_off, fl_req, fl_fetch_en, hv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  fop_e fl_op;
  logic [15:0] fl_addr;
  logic [7:0] fl_wdata;
  logic [7:0] mem [0:255];
  int n_errors = 0;
  int total_checks = 0;
  flash_bank_if link ();
  always #2.5 clk = ~clk;
  flash_bank_dev #(.WRITE_T(3), .ERASE_T(4)) flash_bank_dev_inst (.CLK(clk), .RST(rst),
    .LINK(link), .PROGRAM_STORE_STROBE_N(strobe_n), .EXTERNAL_ACCESS_N(ext_n), .ALE(ale),
    .SEC_BYTE(sec_byte), .FL_REQ(fl_req), .FL_OP(fl_op), .FL_ADDR(fl_addr),
    .FL_WDATA(fl_wdata), .FL_RDATA(fl_rdata), .FL_FETCH_EN(fl_fetch_en), .HIGH_VOLTAGE(hv));
  flash_bank_cpu flash_bank_cpu_inst (.CLK(clk), .RST(rst), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .LINK(link), .IRQ_DISABLE(irq_off));
  flash_bank_sva flash_bank_sva_inst (.CLK(clk), .RST(rst), .sfr_wr(link.sfr_wr),
    .sfr_addr(link.sfr_addr), .sfr_wdata(link.sfr_wdata), .sfr_rdata(link.sfr_rdata),
    .pc_valid(link.pc_valid), .pc_ret(link.pc_ret), .pc_addr(link.pc_addr),
    .map_boot(link.map_boot), .call_req(link.call_req), .call_ack(link.call_ack),
    .ret_acc(link.ret_acc), .ret_data_pointer(link.ret_data_pointer));
  // flash array: read data valid the cycle after the request
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  always @(posedge clk) begin
    if (fl_req) begin
      if (fl_op == FOP_WRITE) mem[fl_addr[7:0]] <= fl_wdata;
      fl_rdata <= mem[fl_addr[7:0]];
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, hb;
    int n;
    n = 0;
    r = 2'b11;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      hb = bready && bvalid;
      if (hb) r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      n++;
    end while (!hb && n < 200);
    if (!hb) n_errors++;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, hb;
    int n;
    n = 0;
    d = 32'h0;
    r = 2'b11;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      hb = rready && rvalid;
      if (hb) d = rdata;
      if (hb) r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (hb) rready <= 1'b0;
      n++;
    end while (!hb && n < 200);
    if (!hb) n_errors++;
  endtask
  task automatic run_op(input logic [2:0] op, input logic [15:0] dp, input logic [7:0] ac,
    input logic [7:0] st, input logic [7:0] ea, input logic [15:0] ed, input logic slow);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    axi_wr(DATA_POINTER_OFF, {16'h0, dp}, r);
    axi_wr(ACC_OFF, {24'h0, ac}, r);
    axi_wr(CTRL_OFF, {28'h0, op, 1'b1}, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    if (slow) begin
      repeat (40) @(posedge clk);
      chk({29'h0, hv, fl_fetch_en, irq_off}, 32'h5);
    end
    n = 0;
    d = 32'h0;
    while (!d[1] && n < 500) begin
      axi_rd(STAT_OFF, d, r);
      n++;
    end
    chk({31'h0, d[1]}, 32'h1);
    chk({24'h0, d[15:8]}, {24'h0, st});
    axi_rd(RES_OFF, d, r);
    chk({8'h0, d[23:0]}, {8'h0, ea, ed});
    axi_wr(STAT_OFF, 32'h2, r);
    chk({31'h0, irq_off}, 32'h0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset_map();
    logic [31:0] d;
    logic [1:0] r;
    chk({24'h0, link.sfr_rdata}, {24'h0, FMC_RESET});
    chk({31'h0, link.map_boot}, 32'h0);
    axi_wr(8'h20, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(8'h20, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
  endtask
  task automatic test_user_ops();
    run_op(FOP_READ, 16'h1263, 8'h00, 8'h15, 8'h39, 16'h1263, 1'b0);
    run_op(FOP_WRITE, 16'h1263, 8'ha7, 8'h15, 8'ha7, 16'h1263, 1'b1);
    run_op(FOP_READ, 16'h1263, 8'h00, 8'h15, 8'ha7, 16'h1263, 1'b0);
    run_op(FOP_PAGE, 16'h1267, 8'h00, 8'h1c, ACC_PAGE, 16'h1260, 1'b1);
    run_op(FOP_BLOCK, 16'h12ab, 8'h00, 8'h13, ACC_BLOCK, 16'h1208, 1'b1);
    run_op(FOP_FULL, 16'h0aaa, 8'h00, 8'h1a, ACC_FULL, DATA_POINTER_FULL, 1'b1);
  endtask
  task automatic test_secure();
    ext_n <= 1'b0;
    do_reset();
    run_op(FOP_PAGE, 16'h1267, 8'h33, 8'h10, 8'h33, 16'h1267, 1'b0);
    run_op(FOP_FULL, 16'h0aaa, 8'h00, 8'h1a, ACC_FULL, DATA_POINTER_FULL, 1'b1);
    run_op(FOP_PAGE, 16'h1267, 8'h00, 8'h1c, ACC_PAGE, 16'h1260, 1'b1);
  endtask
  task automatic test_boot_strap();
    strobe_n <= 1'b0;
    do_reset();
    chk({24'h0, link.sfr_rdata}, 32'hc0);
    chk({31'h0, link.map_boot}, 32'h1);
  endtask
  initial begin
    do_reset();
    sec_byte <= 8'h50;
    test_reset_map();
    test_user_ops();
    test_secure();
    test_boot_strap();
    results();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule // flash_boot_bank_switch_control_tb
